// file: design/sphc_regs.vh
// Constants for the SPI host controller: register map, fields, timing.
// Included by the host controller design files.
`ifndef SPHC_REGS_VH
`define SPHC_REGS_VH

// Wishbone register offsets (byte addresses)
`define SPHC_REG_CMD_WORD   4'h0
`define SPHC_REG_CONTROL    4'h4
`define SPHC_REG_STATUS     4'h8
`define SPHC_REG_RESPONSE   4'hC

// Control register fields
`define SPHC_CTL_GO         0
`define SPHC_CTL_CALPIN     1
`define SPHC_CTL_RSTPIN     2
`define SPHC_CTL_SEQ_LO     4
`define SPHC_CTL_SEQ_HI     6
`define SPHC_CTL_RESET      8'h00

// Status register fields
`define SPHC_ST_BUSY        0
`define SPHC_ST_RESP_VALID  1
`define SPHC_ST_FIRST       2
`define SPHC_ST_IRQ         3
`define SPHC_ST_BADCMD      4

// Command control byte fields
`define SPHC_START_BIT      31
`define SPHC_RSEL_HI        30
`define SPHC_RSEL_LO        29
`define SPHC_WSEL_HI        28
`define SPHC_WSEL_LO        27
`define SPHC_RSVD_HI        26
`define SPHC_RSVD_LO        24

// Selector encodings
`define SPHC_WSEL_NULL      2'h0
`define SPHC_WSEL_MCC       2'h1
`define SPHC_WSEL_ATOMIC    2'h2
`define SPHC_WSEL_REG       2'h3
`define SPHC_RSEL_POS       2'h0

// Device command register and its command codes
`define SPHC_DEV_CMD_ADDR   16'h4000
`define SPHC_CMD_CAL_START  8'h23
`define SPHC_CMD_CAL_STOP   8'h20
`define SPHC_CMD_COPY_BASE  8'h12
`define SPHC_CMD_STORE_EE   8'h11

// Sequencer selections
`define SPHC_SEQ_NONE       2'h0
`define SPHC_SEQ_CAL_START  2'h1
`define SPHC_SEQ_CAL_STOP   2'h2
`define SPHC_SEQ_STORE      2'h3

// Timing
`define SPHC_CLK_HZ         20000000
`define SPHC_EXEC_WAIT_US   10
`define SPHC_FRAME_BITS     32

`endif

// file: design/sphc_sync.v
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes clk is the controller clock; reset is synchronous, active low.
`timescale 1ns/10ps

module sphc_sync #(
    parameter RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Level
    input wire asyncIn,
    output reg syncOut
);

reg meta_q;

always @(posedge clk)
begin
    if (!rstn)
    begin
        meta_q <= RESET_VAL;
        syncOut <= RESET_VAL;
    end
    else
    begin
        meta_q <= asyncIn;
        syncOut <= meta_q;
    end
end

endmodule

// file: design/sphc_host.v
// SPI host controller that drives the interpolator's serial command port.
// Assumes a Wishbone classic master on clk and the device pins on the link.
`timescale 1ns/10ps
`include "sphc_regs.vh"

module sphc_host #(
    parameter HALF_PERIOD = 4,
    parameter EXEC_WAIT = (`SPHC_EXEC_WAIT_US * (`SPHC_CLK_HZ / 1000000))
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Device serial port
    output reg spiClk,
    output reg spiMosi,
    output reg slaveSelectN,
    input wire spiMiso,
    // Device control pins
    output reg calibrateRequestN,
    output reg externalResetN,
    input wire interruptRequestN
);

localparam ST_IDLE = 3'h0;
localparam ST_SETUP = 3'h1;
localparam ST_HIGH = 3'h2;
localparam ST_LOW = 3'h3;
localparam ST_DESEL = 3'h4;
localparam ST_EXEC = 3'h5;

reg [2:0] state_q;
reg [31:0] cmdWord_q;
reg [31:0] shiftOut_q;
reg [31:0] shiftIn_q;
reg [31:0] response_q;
reg [5:0] bitCnt_q;
reg [15:0] divCnt_q;
reg [31:0] waitCnt_q;
reg [1:0] seq_q;
reg [1:0] seqStep_q;
reg respValid_q;
reg firstDone_q;
reg badCmd_q;
reg goReq_q;
reg [7:0] seqCode;
wire misoSync;
wire irqSyncN;
wire wbReq;
wire [31:0] seqWord;
wire cmdLegal;

sphc_sync #(.RESET_VAL(1'b0)) uMisoSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn(spiMiso),
    .syncOut(misoSync)
);

sphc_sync #(.RESET_VAL(1'b1)) uIrqSync (
    .clk(clk),
    .rstn(rstn),
    .asyncIn(interruptRequestN),
    .syncOut(irqSyncN)
);

assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

// Command code sent by the sequencer
always @*
begin
    seqCode = `SPHC_CMD_COPY_BASE;
    case (seq_q)
        `SPHC_SEQ_CAL_START:
            seqCode = `SPHC_CMD_CAL_START;
        `SPHC_SEQ_CAL_STOP:
            seqCode = `SPHC_CMD_CAL_STOP;
        `SPHC_SEQ_STORE:
        begin
            // Store before copy would save stale baseline values
            if (seqStep_q == 2'h0)
                seqCode = `SPHC_CMD_COPY_BASE;
            else
                seqCode = `SPHC_CMD_STORE_EE;
        end
        default:
            seqCode = `SPHC_CMD_COPY_BASE;
    endcase
end

// Sequencer forms command register writes: read selector 0, write selector 3
assign seqWord = {1'b1, `SPHC_RSEL_POS, `SPHC_WSEL_REG, 3'h0,
    `SPHC_DEV_CMD_ADDR, seqCode};

// Host refuses words the device would discard
assign cmdLegal = cmdWord_q[`SPHC_START_BIT] &&
    (cmdWord_q[`SPHC_RSVD_HI:`SPHC_RSVD_LO] == 3'h0);

// Wishbone register file
always @(posedge clk)
begin
    if (!rstn)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
        cmdWord_q <= 32'h0;
        calibrateRequestN <= 1'b1;
        externalResetN <= 1'b1;
        seq_q <= `SPHC_SEQ_NONE;
        goReq_q <= 1'b0;
        badCmd_q <= 1'b0;
    end
    else
    begin
        wb_ack_o <= wbReq;
        if (state_q == ST_SETUP)
            goReq_q <= 1'b0;
        if (state_q == ST_IDLE && goReq_q && seq_q == `SPHC_SEQ_NONE && !cmdLegal)
        begin
            goReq_q <= 1'b0;
            badCmd_q <= 1'b1;
        end
        if (state_q == ST_EXEC && waitCnt_q == 32'h0 && seq_q != `SPHC_SEQ_NONE &&
            !(seq_q == `SPHC_SEQ_STORE && seqStep_q == 2'h0))
            seq_q <= `SPHC_SEQ_NONE;
        if (wbReq && wb_we_i)
        begin
            case (wb_adr_i)
                // Raw words also carry configuration stores from software
                `SPHC_REG_CMD_WORD:
                begin
                    if (wb_sel_i[0])
                        cmdWord_q[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1])
                        cmdWord_q[15:8] <= wb_dat_i[15:8];
                    if (wb_sel_i[2])
                        cmdWord_q[23:16] <= wb_dat_i[23:16];
                    if (wb_sel_i[3])
                        cmdWord_q[31:24] <= wb_dat_i[31:24];
                end
                `SPHC_REG_CONTROL:
                begin
                    if (wb_sel_i[0])
                    begin
                        calibrateRequestN <= !wb_dat_i[`SPHC_CTL_CALPIN];
                        externalResetN <= !wb_dat_i[`SPHC_CTL_RSTPIN];
                        if (wb_dat_i[`SPHC_CTL_GO] && state_q == ST_IDLE && !goReq_q)
                        begin
                            goReq_q <= 1'b1;
                            seq_q <= wb_dat_i[`SPHC_CTL_SEQ_HI-1:`SPHC_CTL_SEQ_LO];
                            badCmd_q <= 1'b0;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (wbReq && !wb_we_i)
        begin
            case (wb_adr_i)
                `SPHC_REG_CMD_WORD:
                    wb_dat_o <= cmdWord_q;
                `SPHC_REG_CONTROL:
                    wb_dat_o <= {24'h0, 2'h0, seq_q, 1'b0, !externalResetN,
                        !calibrateRequestN, goReq_q};
                `SPHC_REG_STATUS:
                    wb_dat_o <= {27'h0, badCmd_q, !irqSyncN, firstDone_q,
                        respValid_q, (state_q != ST_IDLE) || goReq_q};
                `SPHC_REG_RESPONSE:
                    // Residue check left to software reading replies
                    wb_dat_o <= response_q;
                default:
                    wb_dat_o <= 32'h0;
            endcase
        end
    end
end

// Serial engine, mode zero master
always @(posedge clk)
begin
    if (!rstn)
    begin
        state_q <= ST_IDLE;
        spiClk <= 1'b0;
        spiMosi <= 1'b0;
        slaveSelectN <= 1'b1;
        shiftOut_q <= 32'h0;
        shiftIn_q <= 32'h0;
        response_q <= 32'h0;
        bitCnt_q <= 6'h0;
        divCnt_q <= 16'h0;
        waitCnt_q <= 32'h0;
        seqStep_q <= 2'h0;
        respValid_q <= 1'b0;
        firstDone_q <= 1'b0;
    end
    else
    begin
        case (state_q)
            ST_IDLE:
            begin
                spiClk <= 1'b0;
                if (goReq_q && (seq_q != `SPHC_SEQ_NONE || cmdLegal))
                begin
                    shiftOut_q <= (seq_q != `SPHC_SEQ_NONE) ? seqWord : cmdWord_q;
                    slaveSelectN <= 1'b0;
                    bitCnt_q <= 6'h0;
                    divCnt_q <= 16'h0;
                    state_q <= ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // Data set up one cycle less than a half period (HALF_PERIOD - 1 cycles) ahead of the first rising edge
                if (divCnt_q == 16'h0)
                begin
                    spiMosi <= shiftOut_q[31];
                    shiftOut_q <= {shiftOut_q[30:0], 1'b0};
                end
                if (divCnt_q == HALF_PERIOD[15:0] - 16'h1)
                begin
                    divCnt_q <= 16'h0;
                    spiClk <= 1'b1;
                    state_q <= ST_HIGH;
                end
                else
                    divCnt_q <= divCnt_q + 16'h1;
            end
            ST_HIGH:
            begin
                // Miso sample lags by the synchroniser; taken late in the high phase
                if (divCnt_q == HALF_PERIOD[15:0] - 16'h1)
                begin
                    divCnt_q <= 16'h0;
                    shiftIn_q <= {shiftIn_q[30:0], misoSync};
                    spiClk <= 1'b0;
                    bitCnt_q <= bitCnt_q + 6'h1;
                    if (bitCnt_q == `SPHC_FRAME_BITS - 1)
                        state_q <= ST_DESEL;
                    else
                    begin
                        spiMosi <= shiftOut_q[31];
                        shiftOut_q <= {shiftOut_q[30:0], 1'b0};
                        state_q <= ST_LOW;
                    end
                end
                else
                    divCnt_q <= divCnt_q + 16'h1;
            end
            ST_LOW:
            begin
                if (divCnt_q == HALF_PERIOD[15:0] - 16'h1)
                begin
                    divCnt_q <= 16'h0;
                    spiClk <= 1'b1;
                    state_q <= ST_HIGH;
                end
                else
                    divCnt_q <= divCnt_q + 16'h1;
            end
            ST_DESEL:
            begin
                if (divCnt_q == HALF_PERIOD[15:0] - 16'h1)
                begin
                    slaveSelectN <= 1'b1;
                    // Stale count would cut the setup of a follow-on frame
                    divCnt_q <= 16'h0;
                    response_q <= shiftIn_q;
                    respValid_q <= firstDone_q;
                    firstDone_q <= 1'b1;
                    waitCnt_q <= EXEC_WAIT;
                    state_q <= ST_EXEC;
                end
                else
                    divCnt_q <= divCnt_q + 16'h1;
            end
            ST_EXEC:
            begin
                // Execution time not reported by the device; fixed guard wait
                if (waitCnt_q != 32'h0)
                    waitCnt_q <= waitCnt_q - 32'h1;
                else if (seq_q == `SPHC_SEQ_STORE && seqStep_q == 2'h0)
                begin
                    // Copy to baseline must precede the EEPROM store
                    seqStep_q <= 2'h1;
                    shiftOut_q <= {seqWord[31:8], `SPHC_CMD_STORE_EE};
                    slaveSelectN <= 1'b0;
                    bitCnt_q <= 6'h0;
                    state_q <= ST_SETUP;
                end
                else
                begin
                    seqStep_q <= 2'h0;
                    state_q <= ST_IDLE;
                end
            end
            default:
                state_q <= ST_IDLE;
        endcase
    end
end

endmodule

// file: bench/sphc_host_properties.sv
// Port assertions for the SPI host controller.
// Assumes binding to sphc_host; one clock domain.
`timescale 1ns/10ps
`include "sphc_regs.vh"
module sphc_host_properties #(
    parameter HALF_PERIOD = 4,
    parameter EXEC_WAIT = 200
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Wishbone
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    // Device pins
    input wire spiClk,
    input wire spiMosi,
    input wire slaveSelectN,
    input wire calibrateRequestN,
    input wire externalResetN
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    reg clkPrev_q;
    reg [5:0] riseCnt_q;
    reg [15:0] gapCnt_q;
    wire ctlWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
        && wb_adr_i == `SPHC_REG_CONTROL;
    // Gap starts full so the first frame after reset passes
    always @(posedge clk)
    begin
        clkPrev_q <= spiClk;
        if (!rstn || slaveSelectN)
            riseCnt_q <= 6'h00;
        else if (spiClk && !clkPrev_q)
            riseCnt_q <= riseCnt_q + 6'h01;
        if (!rstn)
            gapCnt_q <= 16'(EXEC_WAIT);
        else if (!slaveSelectN)
            gapCnt_q <= 16'h0000;
        else if (gapCnt_q < EXEC_WAIT)
            gapCnt_q <= gapCnt_q + 16'h0001;
    end
    property p_idle_low; slaveSelectN |-> !spiClk; endproperty
    a_idle_low: assert property (p_idle_low) else $error("clock not low outside frame");
    property p_mosi_fall; $changed(spiMosi) && !slaveSelectN |-> !spiClk; endproperty
    a_mosi_fall: assert property (p_mosi_fall) else $error("data moved in high phase");
    property p_sel_hold; $rose(spiClk) |-> !slaveSelectN; endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("clock without select");
    property p_bit_count; $rose(slaveSelectN) |-> riseCnt_q == 6'd32; endproperty
    a_bit_count: assert property (p_bit_count) else $error("frame not 32 bits");
    property p_rise_bound; $rose(spiClk) |-> riseCnt_q < 6'd32; endproperty
    a_rise_bound: assert property (p_rise_bound) else $error("extra clock in frame");
    property p_gap; $fell(slaveSelectN) |-> gapCnt_q >= EXEC_WAIT; endproperty
    a_gap: assert property (p_gap) else $error("frame gap too short");
    property p_cal_pin; ctlWr && wb_dat_i[1] |-> ##[1:3] !calibrateRequestN; endproperty
    a_cal_pin: assert property (p_cal_pin) else $error("calibration pin not low");
    property p_rst_pin; ctlWr && wb_dat_i[2] |-> ##[1:3] !externalResetN; endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin not low");
    c_frame: cover property ($rose(slaveSelectN));
    c_cal: cover property ($fell(calibrateRequestN));
    c_rst: cover property ($fell(externalResetN));
endmodule
bind sphc_host sphc_host_properties #(.HALF_PERIOD(HALF_PERIOD), .EXEC_WAIT(EXEC_WAIT))
    sphc_host_properties_i (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .spiClk(spiClk), .spiMosi(spiMosi), .slaveSelectN(slaveSelectN),
    .calibrateRequestN(calibrateRequestN), .externalResetN(externalResetN));

// file: bench/sphc_dev_model.sv
// Behavioural interpolator serial port: reply is inverse of last command.
// Assumes a mode-zero master; no pull-up on the reply line.
`timescale 1ns/10ps
module sphc_dev_model (
    // Serial port
    input wire sck,
    input wire mosi,
    input wire ssN,
    output reg miso,
    // Control pins
    input wire calN,
    input wire rstN,
    input wire failStart,
    output reg irqN
);
    reg [31:0] rxSr, txSr, rxWord, resp;
    reg [7:0] lastCode, prevCode;
    reg calActive;
    integer bits, frames;
    initial
    begin
        resp = 32'h5A5A0F0F;
        miso = 1'b0;
        irqN = 1'b1;
        frames = 0;
        calActive = 1'b0;
        lastCode = 8'h00;
        prevCode = 8'h00;
    end
    always @(negedge ssN)
    begin
        bits = 0;
        txSr = resp;
        miso = txSr[31];
    end
    always @(posedge sck) if (!ssN)
    begin
        rxSr = {rxSr[30:0], mosi};
        bits = bits + 1;
    end
    always @(negedge sck) if (!ssN)
    begin
        txSr = {txSr[30:0], 1'b0};
        miso = txSr[31];
    end
    // Released line shows neither level reliably
    always @(posedge ssN)
    begin
        miso = ~miso;
        if (bits == 32 && rxSr[31])
        begin
            rxWord = rxSr;
            frames = frames + 1;
            resp = ~rxSr;
            if (rxSr[28:27] == 2'h3 && rxSr[23:8] == 16'h4000)
            begin
                prevCode = lastCode;
                lastCode = rxSr[7:0];
            end
        end
    end
    always @(negedge calN) calActive = 1'b1;
    always @(posedge calN) calActive = 1'b0;
    always @(posedge rstN) irqN = !failStart;
endmodule

// file: bench/sphc_host_bench.sv
// Self-checking bench for the SPI host controller.
// Assumes the design, the device model and the checker are compiled first.
`timescale 1ns/10ps
`include "sphc_regs.vh"
module sphc_host_bench;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, failStart = 1'b0;
    reg [3:0] adr = 4'h0, sel = 4'h0;
    reg [31:0] dat = 32'h0, rd, cmd, prev, rnd = 32'h96BE;
    wire [31:0] datO;
    wire ack, sck, mosi, ssN, miso, calN, rstN, irqN;
    integer errorCnt = 0, checkCount = 0, i, n, f0;
    always #25 clk = ~clk;
    sphc_host #(.HALF_PERIOD(4), .EXEC_WAIT(20)) sphc_host_i (.clk(clk), .rstn(rstn),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .spiClk(sck), .spiMosi(mosi),
        .slaveSelectN(ssN), .spiMiso(miso), .calibrateRequestN(calN),
        .externalResetN(rstN), .interruptRequestN(irqN));
    sphc_dev_model sphc_dev_model_i (.sck(sck), .mosi(mosi), .ssN(ssN), .miso(miso),
        .calN(calN), .rstN(rstN), .failStart(failStart), .irqN(irqN));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [7:0] seqCode(input integer s);
        seqCode = (s == 1) ? 8'h23 : (s == 2) ? 8'h20 : 8'h11;
    endfunction
    task endOfTest;
        if (errorCnt == 0 && checkCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        checkCount = checkCount + 1;
        if (seen !== exp)
        begin
            errorCnt = errorCnt + 1;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Holds the request until ack is sampled high
    task wb(input [3:0] a, input w, input [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= d;
        n = 0;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n = n + 1;
        end
        rd = datO;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 50)
        begin
            errorCnt = errorCnt + 1;
            endOfTest;
        end
    endtask
    task waitIdle;
        integer k;
        k = 0;
        wb(`SPHC_REG_STATUS, 1'b0, 32'h0);
        while (rd[0] !== 1'b0 && k < 400)
        begin
            wb(`SPHC_REG_STATUS, 1'b0, 32'h0);
            k = k + 1;
        end
        if (k == 400)
        begin
            errorCnt = errorCnt + 1;
            endOfTest;
        end
    endtask
    task frame(input [31:0] c, input dbl);
        f0 = sphc_dev_model_i.frames;
        wb(`SPHC_REG_CMD_WORD, 1'b1, c);
        wb(`SPHC_REG_CONTROL, 1'b1, 32'h1);
        if (dbl)
            wb(`SPHC_REG_CONTROL, 1'b1, 32'h1);
        waitIdle;
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wb(`SPHC_REG_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wb(`SPHC_REG_CONTROL, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wb(4'h2, 1'b1, 32'hFFFFFFFF);
        wb(4'h2, 1'b0, 32'h0);
        chk(rd, 32'h0);
        for (i = 0; i < 8; i = i + 1)
        begin
            rnd = lfsr(rnd);
            cmd = {1'b1, rnd[30:29], i[1:0], 3'h0, rnd[23:0]};
            frame(cmd, i == 5);
            chk(sphc_dev_model_i.frames, f0 + 1);
            chk(sphc_dev_model_i.rxWord, cmd);
            wb(`SPHC_REG_STATUS, 1'b0, 32'h0);
            chk(rd[1], i != 0);
            wb(`SPHC_REG_RESPONSE, 1'b0, 32'h0);
            if (i != 0)
                chk(rd, ~prev);
            prev = cmd;
        end
        frame({8'h78, rnd[23:0]}, 1'b0);
        chk(sphc_dev_model_i.frames, f0);
        wb(`SPHC_REG_STATUS, 1'b0, 32'h0);
        chk(rd[4], 1'b1);
        for (i = 1; i < 4; i = i + 1)
        begin
            wb(`SPHC_REG_CONTROL, 1'b1, (i << 4) | 1);
            waitIdle;
            chk(sphc_dev_model_i.lastCode, seqCode(i));
        end
        chk(sphc_dev_model_i.prevCode, 8'h12);
        wb(`SPHC_REG_CONTROL, 1'b1, 32'h2);
        repeat (3) @(posedge clk);
        chk(sphc_dev_model_i.calActive, 1'b1);
        wb(`SPHC_REG_CONTROL, 1'b1, 32'h0);
        repeat (3) @(posedge clk);
        chk(sphc_dev_model_i.calActive, 1'b0);
        failStart <= 1'b1;
        wb(`SPHC_REG_CONTROL, 1'b1, 32'h4);
        wb(`SPHC_REG_CONTROL, 1'b1, 32'h0);
        repeat (4) @(posedge clk);
        wb(`SPHC_REG_STATUS, 1'b0, 32'h0);
        chk(rd[3], 1'b1);
        endOfTest;
    end
    // Runs take a few thousand cycles; forty thousand means a hang
    initial
    begin
        #2000000;
        errorCnt = errorCnt + 1;
        endOfTest;
    end
endmodule
